/* pkg/ccs_pkg.sv */
// constants shared by the coil circuit supervisor
package ccs_pkg;
	// timebase
	localparam int CLK_HZ = 50000000;
	localparam int SEC_MS = 1000;
	localparam int PULSE_MS = 100;
	localparam int SEC_CYCLES = CLK_HZ / 1000 * SEC_MS;
	localparam int PULSE_CYCLES = CLK_HZ / 1000 * PULSE_MS;
	// channels
	localparam int NUM_CH = 3;
	localparam int CH_TRIP = 0;
	localparam int CH_COIL2 = 1;
	localparam int CH_COIL3 = 2;
	// modes
	localparam logic [1:0] MODE_NONE = 2'h0;
	localparam logic [1:0] MODE_ONE = 2'h1;
	localparam logic [1:0] MODE_TWO = 2'h2;
	localparam logic [1:0] MODE_RST = MODE_NONE;
	// failure delay in seconds
	localparam logic [5:0] DLY_MIN = 6'h01;
	localparam logic [5:0] DLY_MAX = 6'h3C;
	localparam logic [5:0] DLY_RST = 6'h05;
	// register map
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_DLY_TRIP = 8'h04;
	localparam logic [7:0] OFS_DLY_COIL2 = 8'h08;
	localparam logic [7:0] OFS_DLY_COIL3 = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	// status field positions
	localparam int ST_FAIL_LSB = 0;
	localparam int ST_SENSE_A_LSB = 8;
	localparam int ST_SENSE_B_LSB = 12;
	localparam int ST_PULSE_BIT = 16;
	localparam int MODE_FLD_W = 2;
	localparam int DLY_FLD_W = 6;
endpackage

/* design/ccs_top.sv */
// coil circuit supervisor: three channels, pulse test, failure delay
//
// Summary of operation
// - three separate supervision channels, each set on its own.
// - mode per channel: 0 none, 1 one-state, 2 two-state; resets to 0.
// - mode 0 runs no supervision; sense inputs pass out as plain inputs.
// - two-state mode judges health as XOR of the two sense inputs.
// - one-state mode uses only the first sense input.
// - per-channel delay 1 to 60 s, step 1 s, reset value 5 s.
// - 100 ms test pulse once per second, sensed during the pulse.
// - each channel owns its fixed pair of sense inputs.
// - enabling a channel takes over its sense pair with no other setup.
// - two-state: flag stays low while exactly one input is active.
// - both inputs active for the delay raises the failure flag.
// - discordance shorter than the delay leaves the flag alone.
// - breaker not moving after trip, lasting past delay, raises flag.
// - supply loss drops inputs; two-state channels fail after their delay, one-state channels read healthy.
// - trip failure inhibits reclose start; channels 2 and 3 do not.
// - trip failure also blocks manual and recloser close commands.
// - channels 2 and 3 run the same algorithm with own timer and flag.
// - failure flags go out, and every flag change gives an event.
// - build without expansion has only the trip channel.
// - channels may run different modes at the same time.
`timescale 1ns/1ps
module ccs_top #(
	parameter bit EXPANSION = 1'b1,
	parameter int SEC_CYCLES = ccs_pkg::SEC_CYCLES,
	parameter int PULSE_CYCLES = ccs_pkg::PULSE_CYCLES
) (
	// clock and reset
	input wire logic CORE_CLK_IN,
	input wire logic RESET_N_IN,
	// register port
	input wire logic [ccs_pkg::ADDR_W-1:0] ADDR_IN,
	input wire logic [31:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [31:0] RDATA_OUT,
	// sense inputs
	input wire logic TRIP_SENSE_A_IN,
	input wire logic TRIP_SENSE_B_IN,
	input wire logic COIL2_SENSE_A_IN,
	input wire logic COIL2_SENSE_B_IN,
	input wire logic COIL3_SENSE_A_IN,
	input wire logic COIL3_SENSE_B_IN,
	// test current pulses
	output logic TRIP_TEST_PULSE_OUT,
	output logic COIL2_TEST_PULSE_OUT,
	output logic COIL3_TEST_PULSE_OUT,
	// failure flags and events
	output logic TRIP_CIRCUIT_FAIL_OUT,
	output logic COIL2_CIRCUIT_FAIL_OUT,
	output logic COIL3_CIRCUIT_FAIL_OUT,
	output logic [2:0] FAIL_EVENT_OUT,
	// breaker control interlocks
	output logic RECLOSE_INHIBIT_OUT,
	output logic CLOSE_BLOCK_OUT,
	// sense inputs as plain status when unsupervised
	output logic [5:0] STATUS_INPUTS_OUT
);

	typedef struct packed {
		logic [31:0] sec_cnt;
		logic tick;
		logic pulse;
		logic [2:0][1:0] mode;
		logic [2:0][5:0] dly;
		logic [2:0][5:0] cnt;
		logic [2:0] fail;
		logic [2:0] evt;
		logic [2:0] test;
		logic reclose_inh;
		logic close_blk;
		logic [5:0] plain;
		logic [31:0] rdata;
	} ccs_state_t;

	ccs_state_t st_reg;
	ccs_state_t st_next;

	logic [2:0] sense_a;
	logic [2:0] sense_b;
	logic [2:0] abnormal;
	logic [2:0] present;

	// unknown mode codes fall back to no supervision
	function automatic logic [1:0] legal_mode(input logic [1:0] m);
		if (m == ccs_pkg::MODE_ONE || m == ccs_pkg::MODE_TWO) begin
			return m;
		end
		return ccs_pkg::MODE_NONE;
	endfunction

	function automatic logic [5:0] clamp_dly(input logic [5:0] d);
		if (d < ccs_pkg::DLY_MIN) begin
			return ccs_pkg::DLY_MIN;
		end
		if (d > ccs_pkg::DLY_MAX) begin
			return ccs_pkg::DLY_MAX;
		end
		return d;
	endfunction

	// fixed input pairs per channel
	assign sense_a = {COIL3_SENSE_A_IN, COIL2_SENSE_A_IN, TRIP_SENSE_A_IN};
	assign sense_b = {COIL3_SENSE_B_IN, COIL2_SENSE_B_IN, TRIP_SENSE_B_IN};
	assign present = EXPANSION ? 3'h7 : 3'h1;

	// one process for all bits keeps a single driver on the vector
	always_comb begin
		abnormal = 3'h0;
		for (int i = 0; i < ccs_pkg::NUM_CH; i++) begin
			case (st_reg.mode[i])
				ccs_pkg::MODE_TWO: abnormal[i] = ~(sense_a[i] ^ sense_b[i]);
				ccs_pkg::MODE_ONE: abnormal[i] = sense_a[i];
				default: abnormal[i] = 1'b0;
			endcase
		end
	end

	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		st_next.evt = 3'h0;
		st_next.rdata = 32'h0000_0000;
		// one second timebase, pulse in the first part of each second
		if (st_reg.sec_cnt == 32'(SEC_CYCLES - 1)) begin
			st_next.sec_cnt = 32'h0000_0000;
		end else begin
			st_next.sec_cnt = st_reg.sec_cnt + 32'h0000_0001;
		end
		st_next.pulse = st_next.sec_cnt < 32'(PULSE_CYCLES);
		// sample at the last cycle of the pulse, while current still flows
		st_next.tick = st_next.sec_cnt == 32'(PULSE_CYCLES - 1);
		// register writes
		if (WR_IN) begin
			case (ADDR_IN)
				ccs_pkg::OFS_MODE: begin
					for (int i = 0; i < ccs_pkg::NUM_CH; i++) begin
						st_next.mode[i] = present[i] ?
							legal_mode(WDATA_IN[2*i +: 2]) : ccs_pkg::MODE_NONE;
					end
				end
				ccs_pkg::OFS_DLY_TRIP:
					st_next.dly[ccs_pkg::CH_TRIP] = clamp_dly(WDATA_IN[5:0]);
				ccs_pkg::OFS_DLY_COIL2:
					st_next.dly[ccs_pkg::CH_COIL2] = clamp_dly(WDATA_IN[5:0]);
				ccs_pkg::OFS_DLY_COIL3:
					st_next.dly[ccs_pkg::CH_COIL3] = clamp_dly(WDATA_IN[5:0]);
				default: begin
				end
			endcase
		end
		// per channel supervision
		for (int i = 0; i < ccs_pkg::NUM_CH; i++) begin
			st_next.test[i] = st_next.pulse &&
				(st_reg.mode[i] != ccs_pkg::MODE_NONE);
			if (st_reg.mode[i] == ccs_pkg::MODE_NONE) begin
				st_next.cnt[i] = 6'h00;
				st_next.fail[i] = 1'b0;
			end else if (st_reg.tick) begin
				if (abnormal[i]) begin
					// saturate so a long fault keeps the flag up
					if (st_reg.cnt[i] < st_reg.dly[i]) begin
						st_next.cnt[i] = st_reg.cnt[i] + 6'h01;
					end
					st_next.fail[i] = (st_reg.cnt[i] + 6'h01) >= st_reg.dly[i];
				end else begin
					st_next.cnt[i] = 6'h00;
					st_next.fail[i] = 1'b0;
				end
			end
			st_next.evt[i] = st_next.fail[i] != st_reg.fail[i];
			st_next.plain[i] = (st_next.mode[i] == ccs_pkg::MODE_NONE) &&
				sense_a[i] && present[i];
			st_next.plain[i+3] = (st_next.mode[i] == ccs_pkg::MODE_NONE) &&
				sense_b[i] && present[i];
		end
		st_next.reclose_inh = st_next.fail[ccs_pkg::CH_TRIP];
		st_next.close_blk = st_next.fail[ccs_pkg::CH_TRIP];
		// register reads, answered in the next cycle
		if (RD_IN) begin
			case (ADDR_IN)
				ccs_pkg::OFS_MODE:
					st_next.rdata = {26'h0, st_reg.mode[2], st_reg.mode[1],
						st_reg.mode[0]};
				ccs_pkg::OFS_DLY_TRIP:
					st_next.rdata = {26'h0, st_reg.dly[ccs_pkg::CH_TRIP]};
				ccs_pkg::OFS_DLY_COIL2:
					st_next.rdata = {26'h0, st_reg.dly[ccs_pkg::CH_COIL2]};
				ccs_pkg::OFS_DLY_COIL3:
					st_next.rdata = {26'h0, st_reg.dly[ccs_pkg::CH_COIL3]};
				ccs_pkg::OFS_STATUS: begin
					st_next.rdata[ccs_pkg::ST_FAIL_LSB +: 3] = st_reg.fail;
					st_next.rdata[ccs_pkg::ST_SENSE_A_LSB +: 3] = sense_a;
					st_next.rdata[ccs_pkg::ST_SENSE_B_LSB +: 3] = sense_b;
					st_next.rdata[ccs_pkg::ST_PULSE_BIT] = st_reg.pulse;
				end
				default: st_next.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			st_reg.sec_cnt <= 32'h0000_0000;
			st_reg.tick <= 1'b0;
			st_reg.pulse <= 1'b0;
			st_reg.mode <= {3{ccs_pkg::MODE_RST}};
			st_reg.dly <= {3{ccs_pkg::DLY_RST}};
			st_reg.cnt <= {3{6'h00}};
			st_reg.fail <= 3'h0;
			st_reg.evt <= 3'h0;
			st_reg.test <= 3'h0;
			st_reg.reclose_inh <= 1'b0;
			st_reg.close_blk <= 1'b0;
			st_reg.plain <= 6'h00;
			st_reg.rdata <= 32'h0000_0000;
		end else begin
			st_reg <= st_next;
		end
	end

	assign RDATA_OUT = st_reg.rdata;
	assign TRIP_TEST_PULSE_OUT = st_reg.test[ccs_pkg::CH_TRIP];
	assign COIL2_TEST_PULSE_OUT = st_reg.test[ccs_pkg::CH_COIL2];
	assign COIL3_TEST_PULSE_OUT = st_reg.test[ccs_pkg::CH_COIL3];
	assign TRIP_CIRCUIT_FAIL_OUT = st_reg.fail[ccs_pkg::CH_TRIP];
	assign COIL2_CIRCUIT_FAIL_OUT = st_reg.fail[ccs_pkg::CH_COIL2];
	assign COIL3_CIRCUIT_FAIL_OUT = st_reg.fail[ccs_pkg::CH_COIL3];
	assign FAIL_EVENT_OUT = st_reg.evt;
	assign RECLOSE_INHIBIT_OUT = st_reg.reclose_inh;
	assign CLOSE_BLOCK_OUT = st_reg.close_blk;
	assign STATUS_INPUTS_OUT = st_reg.plain;

	// checks
	sequence s_normal_sample(int i);
		st_reg.tick && st_reg.mode[i] != ccs_pkg::MODE_NONE && !abnormal[i];
	endsequence

	sequence s_trip_fail_seen;
		TRIP_CIRCUIT_FAIL_OUT ##0 RECLOSE_INHIBIT_OUT;
	endsequence

	property p_mode_legal;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		st_reg.mode[0] != 2'h3 && st_reg.mode[1] != 2'h3 &&
			st_reg.mode[2] != 2'h3;
	endproperty
	a_mode_legal: assert property (p_mode_legal) else $error("bad mode code");

	property p_dly_range;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		st_reg.dly[0] >= ccs_pkg::DLY_MIN && st_reg.dly[0] <= ccs_pkg::DLY_MAX;
	endproperty
	a_dly_range: assert property (p_dly_range) else $error("delay out of range");

	property p_reclose;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		TRIP_CIRCUIT_FAIL_OUT |-> s_trip_fail_seen ##0 CLOSE_BLOCK_OUT;
	endproperty
	a_reclose: assert property (p_reclose) else $error("trip fail not interlocked");

	property p_close_only_trip;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		CLOSE_BLOCK_OUT |-> TRIP_CIRCUIT_FAIL_OUT;
	endproperty
	a_close_only_trip: assert property (p_close_only_trip) else $error("close blocked without trip fail");

	property p_event;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		FAIL_EVENT_OUT[1] == $changed(COIL2_CIRCUIT_FAIL_OUT);
	endproperty
	a_event: assert property (p_event) else $error("event does not match flag change");

	property p_rise_after_tick;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		$rose(TRIP_CIRCUIT_FAIL_OUT) |-> $past(st_reg.tick) &&
			$past(st_reg.cnt[0]) + 6'h01 >= $past(st_reg.dly[0]);
	endproperty
	a_rise_after_tick: assert property (p_rise_after_tick) else $error("fail rose before delay");

	property p_clear_normal;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		s_normal_sample(0) |=> !TRIP_CIRCUIT_FAIL_OUT && st_reg.cnt[0] == 6'h00;
	endproperty
	a_clear_normal: assert property (p_clear_normal) else $error("fail not cleared");

	property p_mode0_quiet;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		st_reg.mode[2] == ccs_pkg::MODE_NONE && !WR_IN |=>
			!COIL3_CIRCUIT_FAIL_OUT && !COIL3_TEST_PULSE_OUT &&
			STATUS_INPUTS_OUT[2] == ($past(COIL3_SENSE_A_IN) && EXPANSION);
	endproperty
	a_mode0_quiet: assert property (p_mode0_quiet) else $error("unsupervised channel active");

	property p_pulse_window;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		TRIP_TEST_PULSE_OUT |-> st_reg.sec_cnt < 32'(PULSE_CYCLES);
	endproperty
	a_pulse_window: assert property (p_pulse_window) else $error("pulse too long");

	property p_no_expansion;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		!EXPANSION |-> !COIL2_CIRCUIT_FAIL_OUT && !COIL3_CIRCUIT_FAIL_OUT;
	endproperty
	a_no_expansion: assert property (p_no_expansion) else $error("absent channel active");

	property p_event_trip;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		FAIL_EVENT_OUT[0] == $changed(TRIP_CIRCUIT_FAIL_OUT);
	endproperty
	a_event_trip: assert property (p_event_trip)
		else $error("trip event does not match flag change");

	property p_event_coil3;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		FAIL_EVENT_OUT[2] == $changed(COIL3_CIRCUIT_FAIL_OUT);
	endproperty
	a_event_coil3: assert property (p_event_coil3)
		else $error("coil3 event does not match flag change");

	property p_dly_coil2;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		st_reg.dly[1] >= ccs_pkg::DLY_MIN && st_reg.dly[1] <= ccs_pkg::DLY_MAX;
	endproperty
	a_dly_coil2: assert property (p_dly_coil2)
		else $error("coil2 delay out of range");

	property p_dly_coil3;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		st_reg.dly[2] >= ccs_pkg::DLY_MIN && st_reg.dly[2] <= ccs_pkg::DLY_MAX;
	endproperty
	a_dly_coil3: assert property (p_dly_coil3)
		else $error("coil3 delay out of range");

	// judging must fall while the test current still flows
	property p_sample_in_pulse;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		st_reg.tick && $stable(st_reg.mode[0]) &&
			st_reg.mode[0] != ccs_pkg::MODE_NONE |-> TRIP_TEST_PULSE_OUT;
	endproperty
	a_sample_in_pulse: assert property (p_sample_in_pulse)
		else $error("sample outside test pulse");

	property p_tick_single;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		st_reg.tick |=> !st_reg.tick;
	endproperty
	a_tick_single: assert property (p_tick_single)
		else $error("more than one sample per second");

	property p_coil2_needs_mode;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		COIL2_CIRCUIT_FAIL_OUT |-> $past(st_reg.mode[1]) != ccs_pkg::MODE_NONE;
	endproperty
	a_coil2_needs_mode: assert property (p_coil2_needs_mode)
		else $error("coil2 flag without supervision");

	property p_reclose_only_trip;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		RECLOSE_INHIBIT_OUT |-> TRIP_CIRCUIT_FAIL_OUT;
	endproperty
	a_reclose_only_trip: assert property (p_reclose_only_trip)
		else $error("reclose inhibited without trip fail");

	// between samples a flag may only move through a mode change
	property p_fail_steady;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		!st_reg.tick && $stable(st_reg.mode) |=>
			$stable(TRIP_CIRCUIT_FAIL_OUT);
	endproperty
	a_fail_steady: assert property (p_fail_steady)
		else $error("flag moved between samples");

	property p_two_state_judge;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		st_reg.mode[1] == ccs_pkg::MODE_TWO |->
			abnormal[1] == (COIL2_SENSE_A_IN == COIL2_SENSE_B_IN);
	endproperty
	a_two_state_judge: assert property (p_two_state_judge)
		else $error("two state judgement wrong");

	property p_mode0_clear;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		st_reg.mode[0] == ccs_pkg::MODE_NONE |=> st_reg.cnt[0] == 6'h00;
	endproperty
	a_mode0_clear: assert property (p_mode0_clear)
		else $error("counter runs without supervision");

endmodule

/* verification/ccs_coil_model.sv */
// breaker auxiliary contacts and three coil circuits seen by the sense pins
`timescale 1ns/1ps
module ccs_coil_model (
	// breaker and circuit conditions
	input wire logic closed_in,
	input wire logic moving_in,
	input wire logic supply_ok_in,
	input wire logic [2:0] coil_open_in,
	// sense pins toward the supervisor
	output logic [2:0] sense_a_out,
	output logic [2:0] sense_b_out
);
	logic aux_a;
	logic aux_b;
	// mid-stroke both contacts make at once, as real contacts do
	assign aux_a = closed_in | moving_in;
	assign aux_b = ~closed_in | moving_in;
	// levels are continuous: the bench only moves them well clear of samples
	// current through an intact circuit pulls its input low
	assign sense_a_out = {3{supply_ok_in}} & ~({3{aux_b}} & ~coil_open_in);
	assign sense_b_out = {3{supply_ok_in}} & ~({3{aux_a}} & ~coil_open_in);
endmodule

/* verification/coil_circuit_supervisor_bench.sv */
// self-checking bench for the coil circuit supervisor
`timescale 1ns/1ps
module coil_circuit_supervisor_bench;
	localparam int SC = 20;
	localparam int PC = 4;
	typedef struct {logic [2:0] ev; logic [2:0] f; int at;} ccs_note_t;
	typedef struct {logic [31:0] v; logic [31:0] m;} ccs_rd_t;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic closed = 1'b0;
	logic moving = 1'b0;
	logic sup = 1'b1;
	logic [2:0] copen = 3'h0;
	logic [2:0] sa, sb, pulse, fail, ev;
	logic recl, cblk, pl, rdp;
	logic [5:0] st;
	logic [2:0] xfail;
	int bad_count = 0;
	int checked = 0;
	int rises = 0;
	ccs_note_t evq[$];
	ccs_rd_t rdq[$];

	always #10 clk = ~clk;

	ccs_coil_model ccs_coil_model_i (.closed_in(closed), .moving_in(moving),
		.supply_ok_in(sup), .coil_open_in(copen), .sense_a_out(sa),
		.sense_b_out(sb));
	ccs_top #(.SEC_CYCLES(SC), .PULSE_CYCLES(PC)) ccs_top_i (
		.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .ADDR_IN(addr),
		.WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
		.TRIP_SENSE_A_IN(sa[0]), .TRIP_SENSE_B_IN(sb[0]),
		.COIL2_SENSE_A_IN(sa[1]), .COIL2_SENSE_B_IN(sb[1]),
		.COIL3_SENSE_A_IN(sa[2]), .COIL3_SENSE_B_IN(sb[2]),
		.TRIP_TEST_PULSE_OUT(pulse[0]), .COIL2_TEST_PULSE_OUT(pulse[1]),
		.COIL3_TEST_PULSE_OUT(pulse[2]), .TRIP_CIRCUIT_FAIL_OUT(fail[0]),
		.COIL2_CIRCUIT_FAIL_OUT(fail[1]), .COIL3_CIRCUIT_FAIL_OUT(fail[2]),
		.FAIL_EVENT_OUT(ev), .RECLOSE_INHIBIT_OUT(recl),
		.CLOSE_BLOCK_OUT(cblk), .STATUS_INPUTS_OUT(st));
	// basic build: only the trip channel exists
	ccs_top #(.EXPANSION(1'b0), .SEC_CYCLES(SC), .PULSE_CYCLES(PC))
		ccs_top_base_i (
		.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .ADDR_IN(addr),
		.WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(),
		.TRIP_SENSE_A_IN(sa[0]), .TRIP_SENSE_B_IN(sb[0]),
		.COIL2_SENSE_A_IN(sa[1]), .COIL2_SENSE_B_IN(sb[1]),
		.COIL3_SENSE_A_IN(sa[2]), .COIL3_SENSE_B_IN(sb[2]),
		.TRIP_TEST_PULSE_OUT(), .COIL2_TEST_PULSE_OUT(),
		.COIL3_TEST_PULSE_OUT(), .TRIP_CIRCUIT_FAIL_OUT(xfail[0]),
		.COIL2_CIRCUIT_FAIL_OUT(xfail[1]), .COIL3_CIRCUIT_FAIL_OUT(xfail[2]),
		.FAIL_EVENT_OUT(), .RECLOSE_INHIBIT_OUT(),
		.CLOSE_BLOCK_OUT(), .STATUS_INPUTS_OUT());

	task automatic check(string n, logic [31:0] s, logic [31:0] e);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s exp %0h seen %0h", n, e, s);
		end
	endtask
	task automatic tally_and_finish();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr_reg(logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(logic [7:0] a, logic [31:0] e, logic [31:0] m = '1);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		rdq.push_back('{e, m});
		@(posedge clk);
		rd <= 1'b0;
	endtask
	task automatic cfg(logic [31:0] m, logic [31:0] d0, d1, d2);
		wr_reg(ccs_pkg::OFS_DLY_TRIP, d0);
		wr_reg(ccs_pkg::OFS_DLY_COIL2, d1);
		wr_reg(ccs_pkg::OFS_DLY_COIL3, d2);
		wr_reg(ccs_pkg::OFS_MODE, m);
	endtask
	task automatic expect_ev(logic [2:0] e, logic [2:0] f, int d);
		evq.push_back('{e, f, rises + d});
	endtask
	// move conditions only after this second's sample has been judged
	task automatic sync();
		int n;
		n = rises;
		while (rises == n)
			@(posedge clk);
		repeat (PC + 3) @(posedge clk);
	endtask

	// result watcher: read data and flag events against the oldest note
	initial begin
		pl = 1'b0;
		rdp = 1'b0;
	end
	always @(negedge clk) begin
		ccs_note_t n;
		ccs_rd_t r;
		if (pulse[0] === 1'b1 && pl === 1'b0)
			rises++;
		pl = pulse[0];
		if (rdp) begin
			r = rdq.pop_front();
			check("rdata", rdata & r.m, r.v);
		end
		rdp = rd;
		if (ev !== 3'h0) begin
			n = evq.size() ? evq.pop_front() : '{3'h0, 3'h0, 0};
			check("event", ev, n.ev);
			check("flags", fail, n.f);
			check("second", rises, n.at);
			check("interlock", {recl, cblk}, {2{n.f[0]}});
		end
	end

	initial begin
		repeat (120 * SC) @(posedge clk);
		bad_count++;
		tally_and_finish();
	end

	initial begin
		int r;
		r = $urandom(21);
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(ccs_pkg::OFS_MODE, 32'h0);
		for (int i = 0; i < 3; i++)
			rd_reg(ccs_pkg::OFS_DLY_TRIP + 8'(4 * i), 32'h5);
		rd_reg(8'h14, 32'h0);
		rd_reg(ccs_pkg::OFS_STATUS, 32'h0, 32'h7);
		wr_reg(ccs_pkg::OFS_DLY_TRIP, 32'h0);
		rd_reg(ccs_pkg::OFS_DLY_TRIP, 32'h1);
		wr_reg(ccs_pkg::OFS_DLY_COIL2, 32'h3D);
		rd_reg(ccs_pkg::OFS_DLY_COIL2, 32'h3C);
		r = $urandom_range(60, 1);
		wr_reg(ccs_pkg::OFS_DLY_COIL3, r);
		rd_reg(ccs_pkg::OFS_DLY_COIL3, r);
		wr_reg(ccs_pkg::OFS_MODE, 32'h3F);
		rd_reg(ccs_pkg::OFS_MODE, 32'h0);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			{sup, closed, moving, copen} <= 6'($urandom());
			repeat (2) @(posedge clk);
			@(negedge clk);
			check("plain", st, {sb, sa});
			check("pulse", pulse, 3'h0);
		end
		@(posedge clk);
		{sup, closed, moving, copen} <= 6'h20;
		$display("test plain inputs done");
		// trip and coil2 two-state, coil3 one-state
		cfg(32'h1A, 2, 3, 2);
		sync();
		copen <= 3'h1;
		expect_ev(3'h1, 3'h1, 2);
		repeat (3 * SC) @(posedge clk);
		sync();
		copen <= 3'h0;
		expect_ev(3'h1, 3'h0, 1);
		repeat (2 * SC) @(posedge clk);
		$display("test coil open done");
		// contacts both made for one sample only
		sync();
		moving <= 1'b1;
		sync();
		closed <= 1'b1;
		moving <= 1'b0;
		expect_ev(3'h4, 3'h4, 2);
		repeat (3 * SC) @(posedge clk);
		sync();
		closed <= 1'b0;
		expect_ev(3'h4, 3'h0, 1);
		repeat (2 * SC) @(posedge clk);
		$display("test switching done");
		cfg(32'h2A, 1, 3, 2);
		sync();
		sup <= 1'b0;
		expect_ev(3'h1, 3'h1, 1);
		expect_ev(3'h4, 3'h5, 2);
		expect_ev(3'h2, 3'h7, 3);
		repeat (4 * SC) @(posedge clk);
		@(negedge clk);
		check("base build", xfail, 3'h1);
		sync();
		sup <= 1'b1;
		expect_ev(3'h7, 3'h0, 1);
		repeat (2 * SC) @(negedge clk);
		check("pending", evq.size(), 0);
		$display("test supply loss done");
		tally_and_finish();
	end
endmodule
